//--- shared/wdog_pkg.sv
// Constants, register map and carrier types of the windowed watchdog
package wdog_pkg;

    // ------------------------------------------------------------------
    // Bus and counter widths
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CNT_W  = 24;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_MODE    = 8'h00;
    localparam logic [7:0] OFS_TIMEOUT = 8'h04;
    localparam logic [7:0] OFS_FEED    = 8'h08;
    localparam logic [7:0] OFS_COUNT   = 8'h0C;
    localparam logic [7:0] OFS_WARN    = 8'h10;
    localparam logic [7:0] OFS_WINDOW  = 8'h14;

    // ------------------------------------------------------------------
    // Mode register fields
    // ------------------------------------------------------------------
    localparam int unsigned MODE_EN_BIT    = 0;
    localparam int unsigned MODE_RSTEN_BIT = 1;
    localparam int unsigned MODE_TOF_BIT   = 2;
    localparam int unsigned MODE_WARNF_BIT = 3;
    localparam int unsigned MODE_RSTF_BIT  = 4;

    // ------------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------------
    localparam logic [23:0] TIMEOUT_RST = 24'h0000FF;
    localparam logic [23:0] TIMEOUT_MIN = 24'h0000FF;
    localparam logic [23:0] WARN_RST    = 24'h000000;
    localparam logic [23:0] WINDOW_RST  = 24'hFFFFFF;

    // ------------------------------------------------------------------
    // Feed keys
    // ------------------------------------------------------------------
    localparam logic [7:0] FEED_KEY1 = 8'hAA;
    localparam logic [7:0] FEED_KEY2 = 8'h55;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned TICK_NOMINAL_KHZ = 500;
    localparam logic [1:0]  PRESCALE_LAST    = 2'h3;
    localparam logic [3:0]  RST_PULSE_LAST   = 4'h7;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_type;

    typedef enum logic [1:0] {
        FEED_IDLE  = 2'b01,
        FEED_ARMED = 2'b10
    } feed_state_type;

endpackage : wdog_pkg

//--- src/wdog_prescaler.sv
// Watchdog tick synchroniser and divide-by-four prescaler
`timescale 1ns/100ps
`default_nettype none

module wdog_prescaler (
    input  wire logic sys_clk_i,
    input  wire logic arst_n_i,
    input  wire logic tick_clk_i,
    input  wire logic run_i,
    output logic      step_o
);

    logic       sync1_q;
    logic       sync2_q;
    logic       prev_q;
    logic [1:0] div_q;
    logic [1:0] div_d;
    logic       step_q;
    logic       step_d;
    logic       edge_w;

    // ------------------------------------------------------------------
    // Two-stage synchroniser and edge history of the tick clock
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
        end else begin
            sync1_q <= tick_clk_i;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    assign edge_w = sync2_q & ~prev_q;

    // Divider steps the counter once per four tick edges
    always_comb begin
        div_d  = div_q;
        step_d = 1'b0;
        if (!run_i) begin
            div_d = 2'h0;
        end else if (edge_w) begin
            div_d = div_q + 2'h1;
            if (div_q == wdog_pkg::PRESCALE_LAST) begin
                step_d = 1'b1;                          // (RULE7) (RULE8)
            end
        end
    end

    // Divider registers
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_q  <= 2'h0;
            step_q <= 1'b0;
        end else begin
            div_q  <= div_d;
            step_q <= step_d;
        end
    end

    assign step_o = step_q;

endmodule : wdog_prescaler

`default_nettype wire

//--- src/windowed_watchdog.sv
// Windowed watchdog: register slave, feed checker, counter and fault response
//
// Operation
// (RULE1) Expiry without reload resets the chip; the code does so only with reset enable set, else it sets the timeout flag
// (RULE2) Windowed mode: reload only inside permitted window
// (RULE3) Warning flag when count reaches warning value
// (RULE4) Enable sticks until hardware or watchdog event
// (RULE5) Bad feed sequence gives reset or interrupt
// (RULE6) Flag records watchdog caused the reset
// (RULE7) 24-bit counter stepped through a prescaler
// (RULE8) Period 256x4 to 2^24x4 tick cycles
// (RULE9) Dedicated free-running tick oscillator clocks it
// (RULE10) Feed is two key writes, then reload
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module windowed_watchdog (
    input  wire logic                 sys_clk_i,
    input  wire logic                 arst_n_i,
    input  wire logic                 wdog_tick_clock_i,
    input  wire wdog_pkg::reg_req_type reg_req_i,
    output logic [31:0]               rd_data_o,
    output logic                      chip_reset_o,
    output logic                      wdog_irq_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic        en_q,      en_d;
    logic        rsten_q,   rsten_d;
    logic        tof_q,     tof_d;
    logic        warnf_q,   warnf_d;
    logic        rstf_q,    rstf_d;
    logic [23:0] timeout_q, timeout_d;
    logic [23:0] warn_q,    warn_d;
    logic [23:0] window_q,  window_d;
    logic [23:0] count_q,   count_d;
    logic [3:0]  pulse_q,   pulse_d;
    logic        crst_q,    crst_d;
    logic        irq_q,     irq_d;
    logic [31:0] rdata_q,   rdata_d;
    wdog_pkg::feed_state_type feed_q, feed_d;

    logic        step_w;
    logic        hit_w;
    logic        wr_mode_w;
    logic        wr_feed_w;
    logic        key1_w;
    logic        key2_w;
    logic        feed_ok_w;
    logic        feed_bad_w;
    logic        win_bad_w;
    logic        expire_w;
    logic        fault_w;
    logic [31:0] wd_w;

    // ------------------------------------------------------------------
    // Tick synchroniser and prescaler
    // ------------------------------------------------------------------
    wdog_prescaler u_prescaler (
        .sys_clk_i  (sys_clk_i),
        .arst_n_i   (arst_n_i),
        .tick_clk_i (wdog_tick_clock_i),                // (RULE9)
        .run_i      (en_q),
        .step_o     (step_w)
    );

    // ------------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------------
    assign wd_w      = reg_req_i.wdata;
    assign hit_w     = reg_req_i.wr | reg_req_i.rd;
    assign wr_mode_w = reg_req_i.wr & (reg_req_i.addr == wdog_pkg::OFS_MODE);
    assign wr_feed_w = reg_req_i.wr & (reg_req_i.addr == wdog_pkg::OFS_FEED);
    assign key1_w    = wr_feed_w & (wd_w[7:0] == wdog_pkg::FEED_KEY1);
    assign key2_w    = wr_feed_w & (wd_w[7:0] == wdog_pkg::FEED_KEY2);

    // ------------------------------------------------------------------
    // Feed sequence checker
    // ------------------------------------------------------------------
    always_comb begin
        feed_d     = feed_q;
        feed_ok_w  = 1'b0;
        feed_bad_w = 1'b0;
        case (feed_q)
            wdog_pkg::FEED_IDLE: begin
                if (key1_w) begin
                    feed_d = wdog_pkg::FEED_ARMED;
                end else if (wr_feed_w) begin
                    feed_bad_w = en_q;                  // (RULE5)
                end
            end
            wdog_pkg::FEED_ARMED: begin
                if (key2_w) begin
                    feed_ok_w = 1'b1;                   // (RULE10)
                    feed_d    = wdog_pkg::FEED_IDLE;
                end else if (key1_w) begin
                    feed_d = wdog_pkg::FEED_ARMED;
                end else if (hit_w) begin
                    feed_bad_w = en_q;                  // (RULE5) (RULE10)
                    feed_d     = wdog_pkg::FEED_IDLE;
                end
            end
            default: begin
                feed_d = wdog_pkg::FEED_IDLE;
            end
        endcase
    end

    // Feed inside the forbidden early part of the window is a fault
    assign win_bad_w = feed_ok_w & en_q & (count_q > window_q);   // (RULE2)
    assign expire_w  = en_q & step_w & (count_q == 24'h000000);   // (RULE1)
    assign fault_w   = expire_w | feed_bad_w | win_bad_w;

    // ------------------------------------------------------------------
    // Control, configuration and flags
    // ------------------------------------------------------------------
    always_comb begin
        en_d      = en_q;
        rsten_d   = rsten_q;
        tof_d     = tof_q;
        warnf_d   = warnf_q;
        rstf_d    = rstf_q;
        timeout_d = timeout_q;
        warn_d    = warn_q;
        window_d  = window_q;
        if (wr_mode_w) begin
            en_d    = en_q | wd_w[wdog_pkg::MODE_EN_BIT];          // (RULE4)
            rsten_d = rsten_q | wd_w[wdog_pkg::MODE_RSTEN_BIT];
            tof_d   = tof_q & ~wd_w[wdog_pkg::MODE_TOF_BIT];
            warnf_d = warnf_q & ~wd_w[wdog_pkg::MODE_WARNF_BIT];
            rstf_d  = rstf_q & ~wd_w[wdog_pkg::MODE_RSTF_BIT];
        end
        if (reg_req_i.wr && reg_req_i.addr == wdog_pkg::OFS_TIMEOUT) begin
            // Values below the floor are raised to it
            if (wd_w[23:0] < wdog_pkg::TIMEOUT_MIN) begin
                timeout_d = wdog_pkg::TIMEOUT_MIN;      // (RULE8)
            end else begin
                timeout_d = wd_w[23:0];
            end
        end
        if (reg_req_i.wr && reg_req_i.addr == wdog_pkg::OFS_WARN) begin
            warn_d = wd_w[23:0];
        end
        if (reg_req_i.wr && reg_req_i.addr == wdog_pkg::OFS_WINDOW) begin
            window_d = wd_w[23:0];
        end
        // Hardware events set after any clear, so a set is never lost
        if (en_q && step_w && count_q == warn_q) begin
            warnf_d = 1'b1;                             // (RULE3)
        end
        if (fault_w) begin
            en_d = 1'b0;                                // (RULE4)
            if (rsten_q) begin
                rstf_d = 1'b1;                          // (RULE6)
            end else begin
                tof_d = 1'b1;                           // (RULE5)
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            en_q      <= 1'b0;
            rsten_q   <= 1'b0;
            tof_q     <= 1'b0;
            warnf_q   <= 1'b0;
            rstf_q    <= 1'b0;
            timeout_q <= wdog_pkg::TIMEOUT_RST;
            warn_q    <= wdog_pkg::WARN_RST;
            window_q  <= wdog_pkg::WINDOW_RST;
            feed_q    <= wdog_pkg::FEED_IDLE;
        end else begin
            en_q      <= en_d;
            rsten_q   <= rsten_d;
            tof_q     <= tof_d;
            warnf_q   <= warnf_d;
            rstf_q    <= rstf_d;
            timeout_q <= timeout_d;
            warn_q    <= warn_d;
            window_q  <= window_d;
            feed_q    <= feed_d;
        end
    end

    // ------------------------------------------------------------------
    // Down counter
    // ------------------------------------------------------------------
    always_comb begin
        count_d = count_q;
        if (!en_q) begin
            count_d = timeout_q;                        // Preloaded while idle
        end else if (feed_ok_w && !win_bad_w) begin
            count_d = timeout_q;                        // (RULE10)
        end else if (step_w && count_q != 24'h000000) begin
            count_d = count_q - 24'h000001;             // (RULE7)
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count_q <= wdog_pkg::TIMEOUT_RST;
        end else begin
            count_q <= count_d;
        end
    end

    // ------------------------------------------------------------------
    // Chip reset pulse, interrupt level and read data
    // ------------------------------------------------------------------
    always_comb begin
        pulse_d = pulse_q;
        crst_d  = 1'b0;
        if (fault_w && rsten_q) begin
            pulse_d = wdog_pkg::RST_PULSE_LAST;
            crst_d  = 1'b1;                             // (RULE1) (RULE5)
        end else if (pulse_q != 4'h0) begin
            pulse_d = pulse_q - 4'h1;
            crst_d  = 1'b1;
        end
        irq_d   = tof_d | warnf_d;                      // (RULE3)
        rdata_d = 32'h00000000;
        if (reg_req_i.rd) begin
            case (reg_req_i.addr)
                wdog_pkg::OFS_MODE: begin
                    rdata_d[wdog_pkg::MODE_EN_BIT]    = en_q;
                    rdata_d[wdog_pkg::MODE_RSTEN_BIT] = rsten_q;
                    rdata_d[wdog_pkg::MODE_TOF_BIT]   = tof_q;
                    rdata_d[wdog_pkg::MODE_WARNF_BIT] = warnf_q;
                    rdata_d[wdog_pkg::MODE_RSTF_BIT]  = rstf_q;   // (RULE6)
                end
                wdog_pkg::OFS_TIMEOUT: rdata_d[23:0] = timeout_q;
                wdog_pkg::OFS_COUNT:   rdata_d[23:0] = count_q;
                wdog_pkg::OFS_WARN:    rdata_d[23:0] = warn_q;
                wdog_pkg::OFS_WINDOW:  rdata_d[23:0] = window_q;
                default:               rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pulse_q <= 4'h0;
            crst_q  <= 1'b0;
            irq_q   <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            pulse_q <= pulse_d;
            crst_q  <= crst_d;
            irq_q   <= irq_d;
            rdata_q <= rdata_d;
        end
    end

    assign rd_data_o    = rdata_q;
    assign chip_reset_o = crst_q;
    assign wdog_irq_o   = irq_q;

endmodule : windowed_watchdog

`default_nettype wire

//--- sim/windowed_watchdog_assertions.sv
// Port-level assertions for the windowed watchdog
`timescale 1ns/100ps
`default_nettype none

module windowed_watchdog_checker (
    input wire logic                  sys_clk_i,
    input wire logic                  arst_n_i,
    input wire logic                  wdog_tick_clock_i,
    input wire wdog_pkg::reg_req_type reg_req_i,
    input wire logic [31:0]           rd_data_o,
    input wire logic                  chip_reset_o,
    input wire logic                  wdog_irq_o
);
    logic [23:0] to_q;
    logic [23:0] to_d;
    logic        rd_mode;
    logic        rd_to;
    logic        rd_unmap;

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);

    // ----------------------------------------------------------------
    // Helper decode and shadow of the timeout register
    // ----------------------------------------------------------------
    // Decode of read strobes by target
    assign rd_mode  = reg_req_i.rd && reg_req_i.addr == wdog_pkg::OFS_MODE;
    assign rd_to    = reg_req_i.rd && reg_req_i.addr == wdog_pkg::OFS_TIMEOUT;
    assign rd_unmap = reg_req_i.rd && !(reg_req_i.addr inside {8'h00, 8'h04, 8'h08,
                      8'h0C, 8'h10, 8'h14});

    // Next shadow value, small writes clamped to the minimum
    always_comb begin
        to_d = to_q;
        if (reg_req_i.wr && reg_req_i.addr == wdog_pkg::OFS_TIMEOUT) begin
            to_d = (reg_req_i.wdata[23:0] < wdog_pkg::TIMEOUT_MIN) ?
                   wdog_pkg::TIMEOUT_MIN : reg_req_i.wdata[23:0];
        end
    end

    // Shadow register
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            to_q <= wdog_pkg::TIMEOUT_RST;
        end else begin
            to_q <= to_d;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_rd_idle_zero: assert property (!$past(reg_req_i.rd) |-> rd_data_o == 32'h0)
        else $error("read data not zero outside a read");
    a_rd_upper_zero: assert property (rd_data_o[31:24] == 8'h00)
        else $error("read data upper byte not zero");
    a_rd_mode_bits: assert property ($past(rd_mode) |-> rd_data_o[31:5] == 27'h0)
        else $error("mode read shows undefined bits");
    a_rd_unmapped: assert property ($past(rd_unmap) |-> rd_data_o == 32'h0)
        else $error("unmapped read not zero");
    a_rd_timeout_val: assert property ($past(rd_to) |-> rd_data_o == {8'h00, $past(to_q)})
        else $error("timeout read differs from clamped write");
    a_rst_pulse_len: assert property ($rose(chip_reset_o) |-> chip_reset_o [*8] ##1 !chip_reset_o)
        else $error("chip reset pulse not eight cycles");
    a_irq_fall_cause: assert property ($fell(wdog_irq_o) |-> $past(reg_req_i.wr, 1)
        && $past(reg_req_i.addr, 1) == wdog_pkg::OFS_MODE)
        else $error("interrupt fell without a mode write");
    a_en_sets: assert property ((reg_req_i.wr && reg_req_i.addr == 8'h00 && reg_req_i.wdata[0])
        ##1 rd_mode |=> rd_data_o[0])
        else $error("enable not set by mode write");
endmodule : windowed_watchdog_checker

bind windowed_watchdog windowed_watchdog_checker i_chk (
    .sys_clk_i         (sys_clk_i),
    .arst_n_i          (arst_n_i),
    .wdog_tick_clock_i (wdog_tick_clock_i),
    .reg_req_i         (reg_req_i),
    .rd_data_o         (rd_data_o),
    .chip_reset_o      (chip_reset_o),
    .wdog_irq_o        (wdog_irq_o)
);
`default_nettype wire

//--- sim/tb_windowed_watchdog.sv
// Self-checking testbench for the windowed watchdog
`timescale 1ns/100ps
`default_nettype none

module tb_windowed_watchdog;
    logic                  sys_clk_i;
    logic                  arst_n_i;
    logic                  tick_q;
    logic [1:0]            div_q;
    wdog_pkg::reg_req_type req;
    logic [31:0]           rd_data;
    logic                  chip_reset;
    logic                  irq;
    logic [31:0]           rv;
    int                    miscompares;
    int                    tests_run;
    int                    cycles;
    int                    n;

    windowed_watchdog i_dut (
        .sys_clk_i         (sys_clk_i),
        .arst_n_i          (arst_n_i),
        .wdog_tick_clock_i (tick_q),
        .reg_req_i         (req),
        .rd_data_o         (rd_data),
        .chip_reset_o      (chip_reset),
        .wdog_irq_o        (irq)
    );

    // ----------------------------------------------------------------
    // Clocks and hang guard
    // ----------------------------------------------------------------
    // System clock, 8 ns period
    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end

    // Free-running tick of 8 cycles, fast to keep runs short; cycle ceiling
    always @(posedge sys_clk_i) begin
        div_q <= div_q + 2'h1;
        if (div_q == 2'h3) begin
            tick_q <= ~tick_q;
        end
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            miscompares++;
            end_sim();
        end
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Write request; held until the next call replaces it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        req <= '{a, d, 1'b0 | 1'b1, 1'b0};
    endtask : wr

    // Read request, data captured in the following cycle
    task automatic get(input logic [7:0] a);
        @(posedge sys_clk_i);
        req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge sys_clk_i);
        req <= '0;
        #1;
        rv = rd_data;
    endtask : get

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        get(a);
        check(what, rv, exp);
    endtask : rd

    // Bus idle, then wait for an interrupt or chip reset
    task automatic wait_for(input int lim, output int took);
        @(posedge sys_clk_i);
        req <= '0;
        #1;
        took = 0;
        while (irq !== 1'b1 && chip_reset !== 1'b1 && took < lim) begin
            @(posedge sys_clk_i);
            #1;
            took++;
        end
    endtask : wait_for

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        arst_n_i = 1'b0;
        req = '0;
        tick_q = 1'b0;
        div_q = 2'h0;
        cycles = 0;
        miscompares = 0;
        tests_run = 0;
        repeat (4) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        // Reset values, unmapped place, clamped timeout
        rd(wdog_pkg::OFS_MODE, 32'h0, "mode");
        rd(wdog_pkg::OFS_WINDOW, {8'h00, wdog_pkg::WINDOW_RST}, "window");
        rd(wdog_pkg::OFS_WARN, 32'h0, "warn");
        rd(8'h20, 32'h0, "unmapped");
        wr(wdog_pkg::OFS_TIMEOUT, 32'h10);
        rd(wdog_pkg::OFS_TIMEOUT, 32'hFF, "timeout floor");
        wr(wdog_pkg::OFS_TIMEOUT, 32'hAB012345);
        wr(wdog_pkg::OFS_COUNT, 32'h5);
        rd(wdog_pkg::OFS_COUNT, 32'h012345, "count width");
        wr(wdog_pkg::OFS_TIMEOUT, 32'hFF);
        $display("test registers done");
        // Enable, stickiness, feed reload, warning, expiry time
        wr(wdog_pkg::OFS_WARN, 32'hF0);
        wr(wdog_pkg::OFS_MODE, 32'h1);
        rd(wdog_pkg::OFS_MODE, 32'h1, "enable");
        wr(wdog_pkg::OFS_MODE, 32'h0);
        rd(wdog_pkg::OFS_MODE, 32'h1, "enable kept");
        wr(wdog_pkg::OFS_FEED, 32'hAA);
        wr(wdog_pkg::OFS_FEED, 32'h55);
        get(wdog_pkg::OFS_COUNT);
        check("count reload", 32'(rv >= 32'hFE && rv <= 32'hFF), 32'h1);
        wait_for(1000, n);
        rd(wdog_pkg::OFS_MODE, 32'h9, "warning flag");
        wr(wdog_pkg::OFS_WARN, 32'h100);
        wr(wdog_pkg::OFS_MODE, 32'h8);
        rd(wdog_pkg::OFS_MODE, 32'h1, "warning cleared");
        check("irq low", irq, 32'h0);
        wr(wdog_pkg::OFS_FEED, 32'hAA);
        wr(wdog_pkg::OFS_FEED, 32'h55);
        wait_for(9000, n);
        check("expiry time", 32'(n >= 8150 && n <= 8240), 32'h1);
        rd(wdog_pkg::OFS_MODE, 32'h4, "expiry flag");
        wr(wdog_pkg::OFS_MODE, 32'h4);
        $display("test counting done");
        // Bad value, broken pair, feed outside the window
        for (int k = 0; k < 3; k++) begin
            if (k == 2) begin
                wr(wdog_pkg::OFS_WINDOW, 32'h80);
            end
            wr(wdog_pkg::OFS_MODE, 32'h1);
            wr(wdog_pkg::OFS_FEED, (k == 0) ? 32'h12 : 32'hAA);
            if (k == 1) begin
                get(wdog_pkg::OFS_COUNT);
            end
            if (k == 2) begin
                wr(wdog_pkg::OFS_FEED, 32'h55);
            end
            wait_for(10, n);
            check("fault irq", irq, 32'h1);
            rd(wdog_pkg::OFS_MODE, 32'h4, "fault flag");
            wr(wdog_pkg::OFS_MODE, 32'h4);
        end
        wr(wdog_pkg::OFS_WINDOW, 32'hFFFFFF);
        $display("test faults done");
        // Reset response, pulse length, cause flag, hardware reset
        wr(wdog_pkg::OFS_MODE, 32'h3);
        wr(wdog_pkg::OFS_FEED, 32'h12);
        wait_for(10, n);
        check("chip reset", chip_reset, 32'h1);
        n = 0;
        while (chip_reset === 1'b1 && n < 20) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        check("reset pulse", 32'(n), 32'(wdog_pkg::RST_PULSE_LAST) + 32'h1);
        rd(wdog_pkg::OFS_MODE, 32'h12, "reset flag");
        wr(wdog_pkg::OFS_MODE, 32'h11);
        @(posedge sys_clk_i);
        arst_n_i <= 1'b0;
        req <= '0;
        repeat (2) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        rd(wdog_pkg::OFS_MODE, 32'h0, "hardware reset");
        $display("test reset response done");
        end_sim();
    end
endmodule : tb_windowed_watchdog
`default_nettype wire
